// >>> rtl/swrl_params.svh
// constants for the serial wiper register loader
// assumes inclusion by bare name from the design files
`ifndef SWRL_PARAMS_SVH
`define SWRL_PARAMS_SVH
`define SWRL_WORD_BITS 10
`define SWRL_ADDR_MSB 9
`define SWRL_ADDR_LSB 8
`define SWRL_DATA_MSB 7
`define SWRL_DATA_LSB 0
`define SWRL_CHANNELS 4
`define SWRL_MIDSCALE 8'h80
`define SWRL_SYNC_STAGES 2
`endif

// >>> rtl/swrl_pkg.sv
// types shared by the serial wiper register loader
// assumes nothing of its surroundings
package swrl_pkg;
  typedef logic [7:0] swrl_wiper_t;
  typedef logic [1:0] swrl_addr_t;
  typedef logic [9:0] swrl_word_t;
endpackage : swrl_pkg

// >>> rtl/swrl_sync.sv
// two-flop level synchroniser into the core clock
// assumes an asynchronous level input
`timescale 1ns/1ns
module swrl_sync (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic async_in,
  input wire logic reset_val,
  output logic sync_out
);
  logic meta_r;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_r <= reset_val;
      sync_out <= reset_val;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : swrl_sync

// >>> rtl/swrl_loader.sv
// serial wiper register loader: shift register on the serial clock, wiper registers on core_clk
// assumes a host that sends 10-bit words msb first and a board pull-up on serial_out
`timescale 1ns/1ns
`include "swrl_params.svh"
module swrl_loader (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  input wire logic midscale_reset_n,
  input wire logic shutdown_n,
  output logic serial_out_o,
  output logic serial_out_oe,
  output swrl_pkg::swrl_wiper_t wiper_position_register_0,
  output swrl_pkg::swrl_wiper_t wiper_position_register_1,
  output swrl_pkg::swrl_wiper_t wiper_position_register_2,
  output swrl_pkg::swrl_wiper_t wiper_position_register_3,
  output logic [3:0] terminal_a_open
);
  // append one bit at the low end; the oldest bit leaves at the top
  function automatic swrl_pkg::swrl_word_t shift_in(
    input swrl_pkg::swrl_word_t word,
    input logic bit_in
  );
    shift_in = {word[`SWRL_WORD_BITS-2:0], bit_in};
  endfunction : shift_in

  function automatic logic hit(
    input swrl_pkg::swrl_addr_t code,
    input int unsigned channel
  );
    hit = (code == channel[1:0]);
  endfunction : hit

  // midscale reset wins over a load
  function automatic swrl_pkg::swrl_wiper_t wiper_next(
    input swrl_pkg::swrl_wiper_t current,
    input logic force_mid_in,
    input logic write_en,
    input swrl_pkg::swrl_wiper_t new_value
  );
    if (force_mid_in) begin
      wiper_next = `SWRL_MIDSCALE;
    end else if (write_en) begin
      wiper_next = new_value;
    end else begin
      wiper_next = current;
    end
  endfunction : wiper_next

  // link side: clocked by the serial clock, no reset
  swrl_pkg::swrl_word_t shift_r;
  swrl_pkg::swrl_word_t shift_nxt;
  logic out_bit_r;
  logic out_bit_nxt;

  assign shift_nxt = cs_n ? shift_r : shift_in(shift_r, serial_in);

  always_ff @(posedge sclk) begin
    shift_r <= shift_nxt;
  end

  // far-end bit, moved on the fall
  assign out_bit_nxt = cs_n ? out_bit_r : shift_r[`SWRL_WORD_BITS-1];

  always_ff @(negedge sclk) begin
    out_bit_r <= out_bit_nxt;
  end

  // core side: every pin passes two flops first
  logic cs_s;
  logic rst_s;
  logic shutdown_n_s;
  logic so_s;

  swrl_sync u_cs (
    .core_clk(core_clk),
    .srst(srst),
    .async_in(cs_n),
    .reset_val(1'b1),
    .sync_out(cs_s)
  );

  swrl_sync u_rs (
    .core_clk(core_clk),
    .srst(srst),
    .async_in(midscale_reset_n),
    .reset_val(1'b1),
    .sync_out(rst_s)
  );

  swrl_sync u_sd (
    .core_clk(core_clk),
    .srst(srst),
    .async_in(shutdown_n),
    .reset_val(1'b1),
    .sync_out(shutdown_n_s)
  );

  swrl_sync u_so (
    .core_clk(core_clk),
    .srst(srst),
    .async_in(out_bit_r),
    .reset_val(1'b1),
    .sync_out(so_s)
  );

  logic cs_d_r;
  logic load_r;
  logic load_nxt;
  swrl_pkg::swrl_word_t word_r;
  swrl_pkg::swrl_word_t word_nxt;

  wire cs_rise = cs_s & ~cs_d_r;
  // shift register is frozen while chip select is high, so one capture is safe
  assign word_nxt = cs_rise ? shift_r : word_r;
  assign load_nxt = cs_rise;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cs_d_r <= 1'b1;
      load_r <= 1'b0;
      word_r <= '0;
    end else begin
      cs_d_r <= cs_s;
      load_r <= load_nxt;
      word_r <= word_nxt;
    end
  end

  wire swrl_pkg::swrl_addr_t addr_code = word_r[`SWRL_ADDR_MSB:`SWRL_ADDR_LSB];
  wire swrl_pkg::swrl_wiper_t data_byte = word_r[`SWRL_DATA_MSB:`SWRL_DATA_LSB];
  wire force_mid = ~rst_s;

  wire write_ch0 = load_r & hit(addr_code, 0);
  wire write_ch1 = load_r & hit(addr_code, 1);
  wire write_ch2 = load_r & hit(addr_code, 2);
  wire write_ch3 = load_r & hit(addr_code, 3);

  swrl_pkg::swrl_wiper_t wiper0_r;
  swrl_pkg::swrl_wiper_t wiper1_r;
  swrl_pkg::swrl_wiper_t wiper2_r;
  swrl_pkg::swrl_wiper_t wiper3_r;
  swrl_pkg::swrl_wiper_t wiper0_nxt;
  swrl_pkg::swrl_wiper_t wiper1_nxt;
  swrl_pkg::swrl_wiper_t wiper2_nxt;
  swrl_pkg::swrl_wiper_t wiper3_nxt;

  assign wiper0_nxt = wiper_next(wiper0_r, force_mid, write_ch0, data_byte);
  assign wiper1_nxt = wiper_next(wiper1_r, force_mid, write_ch1, data_byte);
  assign wiper2_nxt = wiper_next(wiper2_r, force_mid, write_ch2, data_byte);
  assign wiper3_nxt = wiper_next(wiper3_r, force_mid, write_ch3, data_byte);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wiper0_r <= `SWRL_MIDSCALE;
    end else begin
      wiper0_r <= wiper0_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wiper1_r <= `SWRL_MIDSCALE;
    end else begin
      wiper1_r <= wiper1_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wiper2_r <= `SWRL_MIDSCALE;
    end else begin
      wiper2_r <= wiper2_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wiper3_r <= `SWRL_MIDSCALE;
    end else begin
      wiper3_r <= wiper3_nxt;
    end
  end

  assign wiper_position_register_0 = wiper0_r;
  assign wiper_position_register_1 = wiper1_r;
  assign wiper_position_register_2 = wiper2_r;
  assign wiper_position_register_3 = wiper3_r;

  logic [3:0] terminal_nxt;
  logic oe_nxt;

  assign terminal_nxt = {`SWRL_CHANNELS{~shutdown_n_s}};

  // pull low for a 0, release for a 1
  assign oe_nxt = ~so_s;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      terminal_a_open <= 4'h0;
      serial_out_o <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      terminal_a_open <= terminal_nxt;
      serial_out_o <= 1'b0;
      serial_out_oe <= oe_nxt;
    end
  end

endmodule : swrl_loader

// >>> bench/swrl_properties.sv
// loader port checker, bound below
`timescale 1ns/1ns
module swrl_chk (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic midscale_reset_n,
  input wire logic shutdown_n,
  input wire logic serial_out_o,
  input wire logic [7:0] wiper_position_register_0,
  input wire logic [7:0] wiper_position_register_1,
  input wire logic [7:0] wiper_position_register_2,
  input wire logic [7:0] wiper_position_register_3,
  input wire logic [3:0] terminal_a_open
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_mid_low; !midscale_reset_n [*5]; endsequence
  sequence s_shut_low; !shutdown_n [*5]; endsequence
  sequence s_shut_high; shutdown_n [*5]; endsequence
  sequence s_selected; (!cs_n && midscale_reset_n) [*3]; endsequence
  property p_mid;
    s_mid_low |-> wiper_position_register_0 == 8'h80 && wiper_position_register_1 == 8'h80 &&
      wiper_position_register_2 == 8'h80 && wiper_position_register_3 == 8'h80;
  endproperty
  a_mid: assert property (p_mid) else $error("wipers not at midscale");
  property p_off; s_shut_low |-> terminal_a_open == 4'hF; endproperty
  a_off: assert property (p_off) else $error("terminal A not open");
  property p_on; s_shut_high |-> terminal_a_open == 4'h0; endproperty
  a_on: assert property (p_on) else $error("terminal A open without shutdown");
  property p_od; serial_out_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("serial output driven high");
  property p_quiet;
    s_selected |-> $stable({wiper_position_register_0, wiper_position_register_1,
      wiper_position_register_2, wiper_position_register_3});
  endproperty
  a_quiet: assert property (p_quiet) else $error("wiper changed during a frame");
  property p_same; terminal_a_open == {4{terminal_a_open[0]}}; endproperty
  a_same: assert property (p_same) else $error("channels differ in shutdown");
endmodule : swrl_chk
bind swrl_loader swrl_chk u_chk (
  .core_clk(core_clk),
  .srst(srst),
  .cs_n(cs_n),
  .midscale_reset_n(midscale_reset_n),
  .shutdown_n(shutdown_n),
  .serial_out_o(serial_out_o),
  .wiper_position_register_0(wiper_position_register_0),
  .wiper_position_register_1(wiper_position_register_1),
  .wiper_position_register_2(wiper_position_register_2),
  .wiper_position_register_3(wiper_position_register_3),
  .terminal_a_open(terminal_a_open)
);

// >>> bench/swrl_host.sv
// serial host model, sclk only in frames
`timescale 1ns/1ns
module swrl_host (
  output logic sclk = 1'b0,
  output logic cs_n = 1'b1,
  output logic serial_in = 1'b0
);
  // msb first, ten bits per frame
  task automatic send(input logic [9:0] w, input int lead_ns);
    cs_n = 0;
    serial_in = w[9];
    #(lead_ns);
    foreach (w[i]) begin
      serial_in = w[i];
      #3 sclk = 1;
      #3 sclk = 0;
    end
    #3 cs_n = 1;
    serial_in = ~w[0];
  endtask : send
endmodule : swrl_host

// >>> bench/tb.sv
// top bench: loader, host model, checker
`timescale 1ns/1ns
module tb;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic midscale_reset_n = 1'b1;
  logic shutdown_n = 1'b1;
  logic sclk;
  logic cs_n;
  logic serial_in;
  logic so_drive;
  logic so_enable;
  logic [7:0] w [4];
  logic [3:0] term_open;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  // board pull-up on the open-drain line
  wire line_level = so_enable ? so_drive : 1'b1;
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 400) begin
      finish_test(1);
    end
  end
  swrl_host u_host (
    .sclk(sclk),
    .cs_n(cs_n),
    .serial_in(serial_in)
  );
  swrl_loader i_dut (
    .core_clk(core_clk),
    .srst(srst),
    .sclk(sclk),
    .cs_n(cs_n),
    .serial_in(serial_in),
    .midscale_reset_n(midscale_reset_n),
    .shutdown_n(shutdown_n),
    .serial_out_o(so_drive),
    .serial_out_oe(so_enable),
    .wiper_position_register_0(w[0]),
    .wiper_position_register_1(w[1]),
    .wiper_position_register_2(w[2]),
    .wiper_position_register_3(w[3]),
    .terminal_a_open(term_open)
  );
  task automatic chk(input logic [7:0] seen, input logic [7:0] expected);
    checks_done++;
    if (seen !== expected) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, expected);
    end
  endtask : chk
  task automatic t_load;
    logic [7:0] e [4];
    e = '{4{8'h80}};
    foreach (w[a]) begin
      e[a] = 8'(8'h55 * a);
      u_host.send({a[1:0], e[a]}, 0);
      repeat (8) @(negedge core_clk);
      chk(line_level, a[1]);
      chk(so_drive, 8'h00);
      foreach (w[k]) chk(w[k], e[k]);
    end
    $display("load end");
  endtask : t_load
  task automatic t_long;
    u_host.send({2'b01, 8'h3C}, 200);
    repeat (8) @(negedge core_clk);
    chk(w[1], 8'h3C);
    chk(w[0], 8'h00);
    chk(w[3], 8'hFF);
    $display("long frame end");
  endtask : t_long
  task automatic t_pins;
    @(posedge core_clk);
    midscale_reset_n <= 1'b0;
    shutdown_n <= 1'b0;
    repeat (6) @(negedge core_clk);
    foreach (w[k]) chk(w[k], 8'h80);
    chk(term_open, 8'h0F);
    u_host.send({2'b10, 8'h12}, 0);
    repeat (8) @(negedge core_clk);
    chk(w[2], 8'h80);
    @(posedge core_clk);
    midscale_reset_n <= 1'b1;
    shutdown_n <= 1'b1;
    repeat (6) @(negedge core_clk);
    chk(term_open, 8'h00);
    chk(w[2], 8'h80);
    u_host.send({2'b10, 8'h12}, 0);
    repeat (8) @(negedge core_clk);
    chk(w[2], 8'h12);
    $display("pins end");
  endtask : t_pins
  task automatic finish_test(input int bad);
    miscompares += bad;
    $display("%0d checks %0d wrong", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_load();
    t_long();
    t_pins();
    finish_test(0);
  end
endmodule : tb
